// *** rtl/arnf_pkg.sv ***
// Package: register map, field layout and reset values of the request filter
`default_nettype none
package arnf_pkg;
    localparam int APB_AW = 12;
    localparam logic [11:0] OFS_FILTER_SET = 12'h100;
    localparam logic [11:0] OFS_FILTER_CLEAR = 12'h104;
    localparam logic [11:0] OFS_BUS_ID = 12'h108;
    localparam logic [11:0] OFS_STATUS = 12'h10C;
    localparam int ALL_BUSES_BIT = 31;
    localparam int NODE_BASE = 32;
    localparam int NODE_BITS = 31;
    localparam int NODE_W = 6;
    localparam int BUS_W = 10;
    localparam logic [31:0] FILTER_RESET = 32'h00000000;
    localparam logic [9:0] BUS_ID_RESET = 10'h3FF;
    localparam logic [9:0] BUS_LOCAL_ALIAS = 10'h3FF;
    localparam logic [5:0] NODE_ID_RESET = 6'h3F;
    localparam logic [5:0] NODE_BASE_ID = 6'h20;
    localparam int BUS_ID_LSB = 6;
    localparam int STAT_VALID_BIT = 31;
    typedef enum logic [1:0] {
        ARNF_PASS_NONE = 2'b00,
        ARNF_PASS_PHYS = 2'b01,
        ARNF_PASS_ARRC = 2'b10
    } arnf_ctx_t;
endpackage : arnf_pkg
`default_nettype wire

// *** rtl/arnf_decide.sv ***
// Accept decision for one received request from its source identifier
`default_nettype none
module arnf_decide
    import arnf_pkg::*;
(
    input wire logic [31:0] filter,
    input wire logic [BUS_W-1:0] local_bus_id,
    input wire logic [BUS_W-1:0] src_bus,
    input wire logic [NODE_W-1:0] src_node,
    output logic accept
);
    logic is_local;
    logic [NODE_W-1:0] idx;

    always_comb begin
        is_local = (src_bus == local_bus_id) || (src_bus == BUS_LOCAL_ALIAS);
        idx = src_node - NODE_BASE_ID;
        if (!is_local) begin
            accept = filter[ALL_BUSES_BIT];
        end else if (src_node >= NODE_BASE_ID && src_node < 6'h3F) begin
            accept = filter[idx[4:0]];
        end else begin
            accept = 1'b0;
        end
    end
endmodule : arnf_decide
`default_nettype wire

// *** rtl/arnf_top.sv ***
// Top: upper-node asynchronous request filter with APB register access
//
// The APB register port was decided locally.
`default_nettype none
module arnf_top
    import arnf_pkg::*;
#(
    parameter int FILTER_W = 32,
    parameter int NODE_SPAN = NODE_BITS
)
(
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic CLK_EN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [APB_AW-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic PHY_ID_VALID,
    input wire logic [NODE_W-1:0] PHY_NODE_ID,
    input wire logic REQ_VALID,
    input wire logic REQ_TO_PHYS,
    input wire logic [BUS_W-1:0] REQ_SRC_BUS,
    input wire logic [NODE_W-1:0] REQ_SRC_NODE,
    output logic REQ_ACK,
    output logic REQ_QUEUE,
    output logic [1:0] REQ_CTX
);
    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    // Node bits plus the remote-bus bit must fill the data word
    if (FILTER_W != 32) begin : g_bad_width
        $error("filter width must equal the data width");
    end
    if (NODE_SPAN + 1 != FILTER_W || NODE_SPAN != ALL_BUSES_BIT) begin : g_bad_span
        $error("node span must leave the top bit for remote buses");
    end

    // ----------------------------------------
    // Types and functions
    // ----------------------------------------
    typedef enum logic [2:0] {
        ARNF_REG_SET = 3'b000,
        ARNF_REG_CLEAR = 3'b001,
        ARNF_REG_BUS = 3'b010,
        ARNF_REG_STAT = 3'b011,
        ARNF_REG_NONE = 3'b100
    } arnf_reg_t;

    // Register selected by an APB address
    function automatic arnf_reg_t decode_reg(input logic [APB_AW-1:0] addr);
        arnf_reg_t sel;
        sel = ARNF_REG_NONE;
        if (addr == OFS_FILTER_SET) begin
            sel = ARNF_REG_SET;
        end else if (addr == OFS_FILTER_CLEAR) begin
            sel = ARNF_REG_CLEAR;
        end else if (addr == OFS_BUS_ID) begin
            sel = ARNF_REG_BUS;
        end else if (addr == OFS_STATUS) begin
            sel = ARNF_REG_STAT;
        end
        return sel;
    endfunction : decode_reg

    // Ones in the data word set or clear the matching bits
    function automatic logic [31:0] apply_ones(input logic [31:0] cur,
        input logic [31:0] ones, input logic set_not_clear);
        logic [31:0] res;
        res = set_not_clear ? (cur | ones) : (cur & ~ones);
        return res;
    endfunction : apply_ones

    // Read value of the selected register
    function automatic logic [31:0] read_word(input arnf_reg_t sel, input logic [31:0] filt,
        input logic [BUS_W-1:0] bus, input logic [NODE_W-1:0] node, input logic node_ok);
        logic [31:0] word;
        word = 32'h00000000;
        unique case (sel)
            ARNF_REG_SET, ARNF_REG_CLEAR: word = filt;
            ARNF_REG_BUS: word = {16'h0000, bus, node};
            ARNF_REG_STAT: word = {node_ok, 25'h0000000, node};
            default: word = 32'h00000000;
        endcase
        return word;
    endfunction : read_word

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [31:0] filter;
    logic [BUS_W-1:0] local_bus_id;
    logic [NODE_W-1:0] phy_assigned_node_id;
    logic node_id_valid;
    logic accept;
    arnf_reg_t reg_sel;
    logic setup_phase;
    logic access_phase;
    logic wr_en;
    logic rd_en;
    logic mapped;
    logic set_wr;
    logic clear_wr;
    logic bus_wr;
    logic [31:0] next_prdata;
    logic next_ack;
    logic [1:0] next_ctx;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    assign reg_sel = decode_reg(PADDR);
    assign setup_phase = PSEL && !PENABLE;
    assign access_phase = PSEL && PENABLE;
    // Frozen clock enable drops the access as well as the state
    assign wr_en = access_phase && PWRITE && CLK_EN;
    assign rd_en = setup_phase && !PWRITE && CLK_EN;
    assign mapped = (reg_sel != ARNF_REG_NONE);
    assign set_wr = wr_en && (reg_sel == ARNF_REG_SET);
    assign clear_wr = wr_en && (reg_sel == ARNF_REG_CLEAR);
    assign bus_wr = wr_en && (reg_sel == ARNF_REG_BUS);
    // No wait states: every access ends after one access cycle
    assign PREADY = 1'b1;
    assign PSLVERR = access_phase && !mapped;
    // Read data loaded in setup so it stands through the access cycle
    assign next_prdata = read_word(reg_sel, filter, local_bus_id, phy_assigned_node_id,
        node_id_valid);

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            filter <= FILTER_RESET;
        end else if (set_wr) begin
            filter <= apply_ones(filter, PWDATA, 1'b1);
        end else if (clear_wr) begin
            filter <= apply_ones(filter, PWDATA, 1'b0);
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            local_bus_id <= BUS_ID_RESET;
        end else if (bus_wr) begin
            local_bus_id <= PWDATA[BUS_ID_LSB +: BUS_W];
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            phy_assigned_node_id <= NODE_ID_RESET;
            node_id_valid <= 1'b0;
        end else if (CLK_EN && PHY_ID_VALID) begin
            phy_assigned_node_id <= PHY_NODE_ID;
            node_id_valid <= 1'b1;
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            PRDATA <= 32'h00000000;
        end else if (rd_en) begin
            PRDATA <= next_prdata;
        end
    end

    // ----------------------------------------
    // Request decision
    // ----------------------------------------
    arnf_decide u_decide (
        .filter(filter),
        .local_bus_id(local_bus_id),
        .src_bus(REQ_SRC_BUS),
        .src_node(REQ_SRC_NODE),
        .accept(accept)
    );

    // Decision registered so the answer stands one full cycle
    assign next_ack = REQ_VALID && accept;

    always_comb begin
        next_ctx = ARNF_PASS_NONE;
        if (next_ack) begin
            next_ctx = REQ_TO_PHYS ? ARNF_PASS_PHYS : ARNF_PASS_ARRC;
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            REQ_ACK <= 1'b0;
            REQ_QUEUE <= 1'b0;
            REQ_CTX <= ARNF_PASS_NONE;
        end else if (CLK_EN) begin
            REQ_ACK <= next_ack;
            REQ_QUEUE <= next_ack;
            REQ_CTX <= next_ctx;
        end
    end
endmodule : arnf_top
`default_nettype wire

// *** verification/arnf_props.sv ***
// Checker: port relations of the request filter
`default_nettype none
module arnf_props
    import arnf_pkg::*;
(
    input wire logic MCLK, RSTN, CLK_EN, PSEL, PENABLE, PREADY, PSLVERR,
    input wire logic [11:0] PADDR,
    input wire logic REQ_VALID, REQ_TO_PHYS, REQ_ACK, REQ_QUEUE,
    input wire logic [9:0] REQ_SRC_BUS,
    input wire logic [5:0] REQ_SRC_NODE,
    input wire logic [1:0] REQ_CTX
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    sequence s_xfer;
        PSEL && !PENABLE ##1 PSEL && PENABLE;
    endsequence
    a_ack_queue: assert property (REQ_ACK == REQ_QUEUE) else $error("queue differs");
    a_ack_cause: assert property (REQ_ACK |-> $past(REQ_VALID)) else $error("stray ack");
    a_ctx_kind: assert property (REQ_ACK |-> REQ_CTX == ($past(REQ_TO_PHYS) ? 2'b01 : 2'b10))
        else $error("wrong context");
    a_reject_ctx: assert property (!REQ_ACK |-> REQ_CTX == 2'b00) else $error("ctx on reject");
    a_low_node: assert property (REQ_VALID && CLK_EN && REQ_SRC_BUS == 10'h3FF
        && (REQ_SRC_NODE < 6'h20 || REQ_SRC_NODE == 6'h3F) |=> !REQ_ACK)
        else $error("node outside range accepted");
    a_unmapped_err: assert property (s_xfer ##0 !(PADDR inside {12'h100, 12'h104, 12'h108,
        12'h10C}) |-> PSLVERR) else $error("no error on unmapped");
    a_mapped_ok: assert property (s_xfer ##0 (PADDR inside {12'h100, 12'h104}) |-> !PSLVERR)
        else $error("error on filter");
    a_ready_high: assert property (PREADY) else $error("ready low");
endmodule : arnf_props
bind arnf_top arnf_props chk_u (.*);
`default_nettype wire

// *** verification/arnf_remote.sv ***
// Remote bus node issuing request packets
`default_nettype none
module arnf_remote (
    input wire logic MCLK,
    output logic REQ_VALID, REQ_TO_PHYS,
    output logic [9:0] REQ_SRC_BUS,
    output logic [5:0] REQ_SRC_NODE
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {REQ_VALID, REQ_TO_PHYS, REQ_SRC_BUS, REQ_SRC_NODE} = 0;
    task automatic send(input logic [9:0] b, input logic [5:0] n, input logic p);
        @(posedge MCLK);
        {REQ_VALID, REQ_TO_PHYS, REQ_SRC_BUS, REQ_SRC_NODE} <= {1'b1, p, b, n};
        @(posedge MCLK);
        // Source fields no longer valid
        {REQ_VALID, REQ_SRC_BUS, REQ_SRC_NODE} <= {1'b0, ~b, ~n};
    endtask : send
endmodule : arnf_remote
`default_nettype wire

// *** verification/async_request_node_filter_test.sv ***
// Testbench: filter registers and request acceptance
`default_nettype none
module async_request_node_filter_test
    import arnf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic MCLK = 0, RSTN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, PHY_ID_VALID = 0, p, a;
    logic CLK_EN = 1;
    logic [5:0] cn [5] = '{6'h20, 6'h3E, 6'h3D, 6'h1F, 6'h3F};
    logic [11:0] PADDR = 0;
    logic [31:0] PWDATA = 0, PRDATA, rd, f, w;
    logic [9:0] REQ_SRC_BUS, bid, b;
    logic [5:0] REQ_SRC_NODE, PHY_NODE_ID = 0, nd;
    logic PREADY, PSLVERR, REQ_VALID, REQ_TO_PHYS, REQ_ACK, REQ_QUEUE;
    logic [1:0] REQ_CTX;
    int n_fail = 0, total_checks = 0, i;
    arnf_top dut_u (.MCLK, .RSTN, .CLK_EN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
        .PRDATA, .PREADY, .PSLVERR, .PHY_ID_VALID, .PHY_NODE_ID, .REQ_VALID, .REQ_TO_PHYS,
        .REQ_SRC_BUS, .REQ_SRC_NODE, .REQ_ACK, .REQ_QUEUE, .REQ_CTX);
    arnf_remote rem_u (.MCLK, .REQ_VALID, .REQ_TO_PHYS, .REQ_SRC_BUS, .REQ_SRC_NODE);
    initial forever #50 MCLK = ~MCLK;
    task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s exp %h got %h", s, exp, got);
        end
    endtask : chk
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
        @(posedge MCLK) {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, wr, ad, d};
        @(posedge MCLK) PENABLE <= 1;
        i = 0;
        do begin @(posedge MCLK); i++; end while (PREADY !== 1'b1 && i < 50);
        if (i == 50) begin n_fail++; complete_run; end
        rd = PRDATA;
        chk("slverr", PSLVERR, !(ad inside {12'h100, 12'h104, 12'h108, 12'h10C}));
        {PSEL, PENABLE} <= 2'b00;
    endtask : apb
    // ------------------------------
    // Expected acceptance and request check
    // ------------------------------
    function automatic logic exp_acc(input logic [9:0] sb, input logic [5:0] sn);
        if (sb == bid || sb == 10'h3FF) return sn >= 6'h20 && sn != 6'h3F && f[sn - 6'h20];
        return f[31];
    endfunction : exp_acc
    task automatic req(input logic [9:0] sb, input logic [5:0] sn, input logic sp);
        rem_u.send(sb, sn, sp);
        @(negedge MCLK) a = exp_acc(sb, sn);
        chk("ack", {REQ_QUEUE, REQ_ACK}, {a, a});
        chk("ctx", REQ_CTX, a ? (sp ? 2'b01 : 2'b10) : 2'b00);
    endtask : req
    initial begin
        void'($urandom(3181));
        repeat (3) @(posedge MCLK);
        RSTN <= 1;
        apb(0, 12'h100, 0); chk("filter reset", rd, 0);
        apb(0, 12'h108, 0); chk("bus id reset", rd[15:6], 10'h3FF);
        nd = $urandom;
        @(posedge MCLK) {PHY_ID_VALID, PHY_NODE_ID} <= {1'b1, nd};
        @(posedge MCLK) PHY_ID_VALID <= 0;
        apb(0, 12'h10C, 0); chk("node id", rd, {1'b1, 25'h0, nd});
        apb(1, 12'h200, 1); apb(0, 12'h200, 0); chk("unmapped", rd, 0);
        @(negedge MCLK) CLK_EN <= 0;
        apb(1, 12'h100, 32'h00000002);
        CLK_EN <= 1;
        apb(0, 12'h100, 0); chk("frozen write", rd, 0);
        f = 32'h40000001; bid = 10'h3FF;
        apb(1, 12'h100, f);
        foreach (cn[k]) req(10'h3FF, cn[k], k[0]);
        req(10'h155, 6'h20, 1); f[31] = 1; apb(1, 12'h100, f); req(10'h155, 6'h01, 0);
        $display("corner cases done");
        repeat (60) begin
            w = $urandom; apb(1, 12'h100, w); f |= w;
            w = $urandom; apb(1, 12'h104, w); f &= ~w;
            apb(0, 12'h104, 0); chk("filter", rd, f);
            if ($urandom % 2) begin bid = $urandom; apb(1, 12'h108, {bid, 6'h0}); end
            repeat (6) begin
                b = ($urandom % 3 == 0) ? 10'($urandom) : ($urandom % 2 ? bid : 10'h3FF);
                req(b, 6'($urandom), 1'($urandom));
            end
        end
        $display("random traffic done");
        complete_run;
    end
endmodule : async_request_node_filter_test
`default_nettype wire
